/* bench/bml_bus_master_asserts.sv */
// pin checker for the byte lane bus master
`timescale 1ns/1ps
`default_nettype none
`include "bml_cfg.svh"
module bml_bus_master_chk (
  // watched pins
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst_b,
  input wire logic                   o_busy,
  input wire logic                   o_done,
  input wire logic [`BML_ADDR_W-1:0] o_word_address_lines,
  input wire logic                   o_addr_oe,
  input wire logic [`BML_DATA_W-1:0] o_bus_data_lines,
  input wire logic                   o_data_oe,
  input wire logic                   o_address_valid_strobe_b,
  input wire logic                   o_upper_lane_strobe_b,
  input wire logic                   o_lower_lane_strobe_b,
  input wire logic                   o_read_not_write,
  input wire logic [`BML_CODE_W-1:0] o_cycle_type_code,
  input wire logic                   i_transfer_complete_ack_b
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_cycle_on; !o_address_valid_strobe_b; endsequence
  sequence s_ack_in; $fell(i_transfer_complete_ack_b); endsequence
  chk_strobe_addr: assert property (s_cycle_on |-> o_addr_oe)
    else $error("strobe without address");
  chk_lane_cycle: assert property (!(o_upper_lane_strobe_b && o_lower_lane_strobe_b) |-> s_cycle_on)
    else $error("lane strobe outside cycle");
  chk_write_drive: assert property (o_data_oe |-> !o_read_not_write)
    else $error("data driven in read");
  chk_iack_lines: assert property (s_cycle_on and o_cycle_type_code == `BML_IACK_CODE |->
    o_word_address_lines[22:3] == `BML_ADDR_ONES && o_upper_lane_strobe_b) else $error("bad iack lines");
  chk_byte_copy: assert property (o_data_oe && (o_upper_lane_strobe_b != o_lower_lane_strobe_b) |->
    o_bus_data_lines[15:8] == o_bus_data_lines[7:0]) else $error("byte not copied");
  chk_hold_bus: assert property (s_cycle_on ##1 s_cycle_on |-> $stable(o_word_address_lines) &&
    $stable(o_read_not_write) && $stable(o_cycle_type_code)) else $error("bus moved in cycle");
  chk_ack_done: assert property (s_cycle_on ##0 s_ack_in |-> ##[1:6] o_done)
    else $error("ack not answered");
  chk_done_end: assert property (o_done |-> o_address_valid_strobe_b && o_upper_lane_strobe_b &&
    o_lower_lane_strobe_b && !$past(i_transfer_complete_ack_b, 2)) else $error("bad cycle end");
  chk_idle_quiet: assert property (!o_busy |-> o_address_valid_strobe_b && o_read_not_write)
    else $error("bus active when idle");
endmodule : bml_bus_master_chk
bind bml_bus_master bml_bus_master_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .o_busy(o_busy),
  .o_done(o_done), .o_word_address_lines(o_word_address_lines), .o_addr_oe(o_addr_oe),
  .o_bus_data_lines(o_bus_data_lines), .o_data_oe(o_data_oe), .o_address_valid_strobe_b(o_address_valid_strobe_b),
  .o_upper_lane_strobe_b(o_upper_lane_strobe_b), .o_lower_lane_strobe_b(o_lower_lane_strobe_b),
  .o_read_not_write(o_read_not_write), .o_cycle_type_code(o_cycle_type_code),
  .i_transfer_complete_ack_b(i_transfer_complete_ack_b));
`default_nettype wire

/* bench/bml_slave_model.sv */
// memory slave answering the bus master
`timescale 1ns/1ps
`default_nettype none
module bml_slave_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_as_b,
  input  wire logic        i_uds_b,
  input  wire logic        i_lds_b,
  input  wire logic        i_rnw,
  input  wire logic [22:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [1:0]  i_wait,
  output logic             o_ack_b,
  output logic [15:0]      o_rdata
);
  logic [15:0] mem [16];
  int          cnt;
  initial begin
    o_ack_b = 1'b1;
    o_rdata = 16'h0000;
    cnt = 0;
    foreach (mem[k]) mem[k] = 16'h0000;
  end
  always @(negedge i_sys_clk) begin
    if (i_as_b) begin
      o_ack_b <= 1'b1;
      cnt <= 0;
      o_rdata <= ~o_rdata; // released lines must not keep the last value
    end else if (!(i_uds_b && i_lds_b)) begin
      if (i_rnw) o_rdata <= (i_addr[22:3] == 20'hf_ffff) ? {8'h00, 5'h08, i_addr[2:0]} : mem[i_addr[3:0]];
      if (cnt == int'(i_wait)) begin
        o_ack_b <= 1'b0;
        if (!i_rnw && !i_uds_b) mem[i_addr[3:0]][15:8] <= i_wdata[15:8];
        if (!i_rnw && !i_lds_b) mem[i_addr[3:0]][7:0] <= i_wdata[7:0];
      end else cnt <= cnt + 1;
    end
  end
endmodule : bml_slave_model
`default_nettype wire

/* bench/test_bml_bus_master.sv */
// self-checking bench for the byte lane bus master
`timescale 1ns/1ps
`default_nettype none
`include "bml_cfg.svh"
module test_bml_bus_master;
  import bml_pkg::*;
  logic i_sys_clk = 1'b0, i_rst_b = 1'b0, i_req = 1'b0, i_read = 1'b0, i_iack = 1'b0;
  bml_size_type i_size = BML_SIZE_WORD;
  logic [23:0] i_byte_addr = 24'h00_0000;
  logic [2:0] i_cycle_type = 3'h1, i_level = 3'h0, code;
  logic [15:0] i_wdata = 16'h0000, rdata, wdo, sd, dq, ref_mem [16];
  logic busy, done, aoe, doe, as_b, u_b, l_b, rnw, ack_b;
  logic [22:0] wa;
  logic [1:0] wt = 2'h0;
  int err_count = 0, n_tests = 0, seed = 21414;
  assign dq = doe ? wdo : sd; // master owns the lines only while it drives
  always #12.5 i_sys_clk = ~i_sys_clk;
  bml_bus_master DUT (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_req(i_req), .i_read(i_read), .i_iack(i_iack),
    .i_size(i_size), .i_byte_addr(i_byte_addr), .i_cycle_type(i_cycle_type), .i_level(i_level), .i_wdata(i_wdata),
    .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_word_address_lines(wa), .o_addr_oe(aoe),
    .o_bus_data_lines(wdo), .o_data_oe(doe), .i_bus_data_lines(dq), .o_address_valid_strobe_b(as_b),
    .o_upper_lane_strobe_b(u_b), .o_lower_lane_strobe_b(l_b), .o_read_not_write(rnw),
    .o_cycle_type_code(code), .i_transfer_complete_ack_b(ack_b));
  bml_slave_model u_slave (.i_sys_clk(i_sys_clk), .i_as_b(as_b), .i_uds_b(u_b), .i_lds_b(l_b), .i_rnw(rnw),
    .i_addr(wa), .i_wdata(dq), .i_wait(wt), .o_ack_b(ack_b), .o_rdata(sd));
  //////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic [1:0] lanes(input logic ia, input bml_size_type s, input logic a0);
    return ia ? 2'b10 : (s == BML_SIZE_WORD) ? 2'b00 : a0 ? 2'b10 : 2'b01;
  endfunction : lanes
  task automatic xfer(input logic r, input logic ia, input bml_size_type s, input logic [23:0] a, input logic [15:0] w);
    logic [22:0] sa;
    logic [5:0] sl;
    logic [15:0] m;
    logic [15:0] e;
    @(negedge i_sys_clk);
    i_req <= 1'b1; i_read <= r; i_iack <= ia; i_size <= s; i_byte_addr <= a; i_wdata <= w;
    for (int n = 0; n < 20 && busy !== 1'b1; n++) @(negedge i_sys_clk);
    i_req <= 1'b0;
    for (int n = 0; n < 60 && done !== 1'b1; n++) begin
      @(negedge i_sys_clk);
      if (!(u_b && l_b)) {sa, sl} = {wa, rnw, code, u_b, l_b};
    end
    @(negedge i_sys_clk);
    check(sa, ia ? {20'hf_ffff, i_level} : a[23:1]);
    check(sl, {r || ia, ia ? 3'h7 : i_cycle_type, lanes(ia, s, a[0])});
    m = {{8{!sl[1]}}, {8{!sl[0]}}};
    e = ia ? {8'h00, 5'h08, i_level} : ref_mem[a[4:1]];
    if (r || ia) check(rdata & m, e & m);
    else ref_mem[a[4:1]] = (s == BML_SIZE_WORD) ? w : (ref_mem[a[4:1]] & ~m) | ({2{w[7:0]}} & m);
    for (int n = 0; n < 20 && busy !== 1'b0; n++) @(negedge i_sys_clk);
  endtask : xfer
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////
  initial begin
    foreach (ref_mem[k]) ref_mem[k] = 16'h0000;
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_rst_b = 1'b1;
    // back-to-back word write, two byte writes, then word read back
    xfer(1'b0, 1'b0, BML_SIZE_WORD, 24'h00_0004, 16'ha5c3);
    xfer(1'b0, 1'b0, BML_SIZE_BYTE, 24'h00_0004, 16'h0011);
    xfer(1'b0, 1'b0, BML_SIZE_BYTE, 24'h00_0005, 16'h0022);
    xfer(1'b1, 1'b0, BML_SIZE_WORD, 24'h00_0004, 16'h0000);
    $display("lane test done");
    for (int k = 0; k < 8; k++) begin
      i_level = k[2:0];
      xfer(1'b1, 1'b1, BML_SIZE_BYTE, 24'h00_0000, 16'h0000);
    end
    $display("iack test done");
    for (int k = 0; k < 40; k++) begin
      wt = 2'($random(seed));
      i_cycle_type = 3'($random(seed)) % 3'h7;
      if ($random(seed) & 1) xfer(1'($random(seed)), 1'b0, BML_SIZE_WORD, 24'($random(seed)) & 24'h00_001e, 16'($random(seed)));
      else xfer(1'($random(seed)), 1'b0, BML_SIZE_BYTE, 24'($random(seed)) & 24'h00_001f, 16'($random(seed)));
    end
    $display("random test done");
    summarize;
  end
  initial begin
    #500000;
    err_count++;
    summarize;
  end
endmodule : test_bml_bus_master
`default_nettype wire

/* rtl/bml_ack_sync.sv */
// two-stage synchroniser for the acknowledge input
`timescale 1ns/1ps
`default_nettype none
`include "bml_cfg.svh"

module bml_ack_sync (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  // async level in, synchronised level out
  input  wire logic i_level,
  output logic      o_level
);

  typedef struct packed {
    logic [`BML_SYNC_DEPTH-1:0] stage;
  } bml_sync_state_type;

  bml_sync_state_type st;
  bml_sync_state_type next_st;

  always_comb begin
    next_st       = st;
    // first stage only feeds the second stage
    next_st.stage = {st.stage[`BML_SYNC_DEPTH-2:0], i_level};
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.stage[`BML_SYNC_DEPTH-1];

endmodule : bml_ack_sync
`default_nettype wire

/* rtl/bml_bus_master.sv */
// asynchronous byte lane bus master: one transfer per user request
`timescale 1ns/1ps
`default_nettype none
`include "bml_cfg.svh"

module bml_bus_master (
  // clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst_b,
  // user request
  input  wire logic                      i_req,
  input  wire logic                      i_read,
  input  wire logic                      i_iack,
  input  wire bml_pkg::bml_size_type     i_size,
  input  wire logic [`BML_ADDR_W:0]      i_byte_addr,
  input  wire logic [`BML_CODE_W-1:0]    i_cycle_type,
  input  wire logic [`BML_LEVEL_W-1:0]   i_level,
  input  wire logic [`BML_DATA_W-1:0]    i_wdata,
  // user answer
  output logic                           o_busy,
  output logic                           o_done,
  output logic [`BML_DATA_W-1:0]         o_rdata,
  // bus pins
  output logic [`BML_ADDR_W-1:0]         o_word_address_lines,
  output logic                           o_addr_oe,
  output logic [`BML_DATA_W-1:0]         o_bus_data_lines,
  output logic                           o_data_oe,
  input  wire logic [`BML_DATA_W-1:0]    i_bus_data_lines,
  output logic                           o_address_valid_strobe_b,
  output logic                           o_upper_lane_strobe_b,
  output logic                           o_lower_lane_strobe_b,
  output logic                           o_read_not_write,
  output logic [`BML_CODE_W-1:0]         o_cycle_type_code,
  input  wire logic                      i_transfer_complete_ack_b
);

  import bml_pkg::*;

  typedef struct packed {
    bml_state_type             fsm;
    logic [`BML_ADDR_W-1:0]    addr;
    logic                      addr_oe;
    logic [`BML_DATA_W-1:0]    wdata;
    logic                      data_oe;
    logic                      as_b;
    logic                      uds_b;
    logic                      lds_b;
    logic                      rnw;
    logic [`BML_CODE_W-1:0]    code;
    logic [1:0]                lanes_b;
    logic                      busy;
    logic                      done;
    logic [`BML_DATA_W-1:0]    rdata;
  } bml_state_reg_type;

  bml_state_reg_type st;
  bml_state_reg_type next_st;
  logic              ack_seen;

  ////////////////////////////////////////////////////////////////////////////
  // lane strobe decode, active low {upper, lower}
  function automatic logic [1:0] lane_strobes_b(input bml_size_type size, input logic byte_sel);
    if (size == BML_SIZE_WORD) begin
      lane_strobes_b = 2'h0;
    end else if (byte_sel) begin
      lane_strobes_b = 2'h2;
    end else begin
      lane_strobes_b = 2'h1;
    end
  endfunction : lane_strobes_b

  ////////////////////////////////////////////////////////////////////////////
  // write data per lane: a lone byte goes out on both lanes
  function automatic logic [`BML_DATA_W-1:0] lane_data(input bml_size_type           size,
                                                       input logic [`BML_DATA_W-1:0] data);
    if (size == BML_SIZE_BYTE) begin
      lane_data = {2{data[7:0]}};
    end else begin
      lane_data = data;
    end
  endfunction : lane_data

  ////////////////////////////////////////////////////////////////////////////
  // safe bus state: strobes negated, drivers off, no cycle in flight
  function automatic bml_state_reg_type released(input bml_state_reg_type s);
    released         = s;
    released.fsm     = BML_ST_IDLE;
    released.as_b    = 1'b1;
    released.uds_b   = 1'b1;
    released.lds_b   = 1'b1;
    released.addr_oe = 1'b0;
    released.data_oe = 1'b0;
    released.rnw     = 1'b1;
    released.code    = `BML_IDLE_CODE;
    released.busy    = 1'b0;
    released.done    = 1'b0;
  endfunction : released

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge is asynchronous to our clock, so it is synchronised first
  bml_ack_sync u_ack_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_level   (~i_transfer_complete_ack_b),
    .o_level   (ack_seen)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    case (st.fsm)
      BML_ST_IDLE: begin
        // wait for the slave to drop its ack before a new cycle
        if (i_req && !ack_seen) begin
          next_st.fsm     = BML_ST_ADDR;
          next_st.busy    = 1'b1;
          next_st.rnw     = i_read || i_iack;
          next_st.addr_oe = 1'b1;
          if (i_iack) begin
            next_st.addr    = {`BML_ADDR_ONES, i_level};
            next_st.code    = `BML_IACK_CODE;
            next_st.lanes_b = 2'h2;
          end else begin
            next_st.addr    = i_byte_addr[`BML_ADDR_W:1];
            next_st.code    = i_cycle_type;
            next_st.lanes_b = lane_strobes_b(i_size, i_byte_addr[0]);
          end
          next_st.wdata = lane_data(i_size, i_wdata);
        end
      end
      BML_ST_ADDR: begin
        // address has settled one cycle before the strobe qualifies it
        next_st.fsm     = BML_ST_STROBE;
        next_st.as_b    = 1'b0;
        next_st.data_oe = !st.rnw;
        if (st.rnw) begin
          next_st.uds_b = st.lanes_b[1];
          next_st.lds_b = st.lanes_b[0];
        end
      end
      BML_ST_STROBE: begin
        // write strobes follow data by one cycle so data is valid under them
        next_st.fsm   = BML_ST_WAIT;
        next_st.uds_b = st.lanes_b[1];
        next_st.lds_b = st.lanes_b[0];
      end
      BML_ST_WAIT: begin
        // everything holds while the slave stretches the cycle
        if (ack_seen) begin
          next_st.fsm   = BML_ST_END;
          next_st.as_b  = 1'b1;
          next_st.uds_b = 1'b1;
          next_st.lds_b = 1'b1;
          next_st.done  = 1'b1;
          if (st.rnw) begin
            next_st.rdata = i_bus_data_lines;
          end
        end
      end
      BML_ST_END: begin
        // drivers let go one cycle after the strobes, for hold time
        next_st.fsm     = BML_ST_IDLE;
        next_st.busy    = 1'b0;
        next_st.data_oe = 1'b0;
        next_st.addr_oe = 1'b0;
        next_st.rnw     = 1'b1;
        next_st.code    = `BML_IDLE_CODE;
      end
      default: begin
        // an undefined state encoding (5 to 7) lands here, so park the bus instead
        next_st = released(st);
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st       <= '0;
      st.as_b  <= 1'b1;
      st.uds_b <= 1'b1;
      st.lds_b <= 1'b1;
      st.rnw   <= 1'b1;
      st.fsm   <= BML_ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user side
  assign o_busy                   = st.busy;
  assign o_done                   = st.done;
  assign o_rdata                  = st.rdata;
  // bus side
  assign o_word_address_lines     = st.addr;
  assign o_addr_oe                = st.addr_oe;
  assign o_bus_data_lines         = st.wdata;
  assign o_data_oe                = st.data_oe;
  assign o_address_valid_strobe_b = st.as_b;
  assign o_upper_lane_strobe_b    = st.uds_b;
  assign o_lower_lane_strobe_b    = st.lds_b;
  assign o_read_not_write         = st.rnw;
  assign o_cycle_type_code        = st.code;

endmodule : bml_bus_master
`default_nettype wire

/* rtl/bml_cfg.svh */
// constants for the byte lane bus master
`ifndef BML_CFG_SVH
`define BML_CFG_SVH

`define BML_ADDR_W        23
`define BML_DATA_W        16
`define BML_CODE_W        3
`define BML_LEVEL_W       3
`define BML_IACK_CODE     3'h7
`define BML_IDLE_CODE     3'h0
`define BML_ADDR_ONES     20'hf_ffff
`define BML_SETUP_NS      25
`define BML_CLK_NS        25
`define BML_SETUP_CYC     ((`BML_SETUP_NS + `BML_CLK_NS - 1) / `BML_CLK_NS)
`define BML_SYNC_DEPTH    2

`endif

/* rtl/bml_pkg.sv */
// types for the byte lane bus master
`include "bml_cfg.svh"

package bml_pkg;

  typedef enum logic [1:0] {
    BML_SIZE_BYTE,
    BML_SIZE_WORD
  } bml_size_type;

  typedef enum logic [2:0] {
    BML_ST_IDLE,
    BML_ST_ADDR,
    BML_ST_STROBE,
    BML_ST_WAIT,
    BML_ST_END
  } bml_state_type;

endpackage : bml_pkg
